// file: rtl/rtp_pkg.sv
// constants, field layout and bus states of the rtc interrupt, trim and power control block
// assumes a 200 MHz core clock and a free-running 32.768 kHz oscillator square wave on a pin
package rtp_pkg;
  localparam logic [6:0] DEV_ADDR = 7'h6f;
  localparam logic [15:0] ADDR_INT = 16'h0011;
  localparam logic [15:0] ADDR_ATR = 16'h0012;
  localparam logic [15:0] ADDR_DTR = 16'h0013;
  localparam logic [15:0] ADDR_PWR = 16'h0014;
  localparam logic [15:0] ADDR_SR = 16'h003f;
  localparam logic [15:0] ADDR_STEP = 16'h0001;
  // factory contents of the control bytes; pwr reset code bits are product straps
  localparam logic [7:0] INT_RST = 8'h00;
  localparam logic [7:0] ATR_RST = 8'h00;
  localparam logic [7:0] DTR_RST = 8'h00;
  localparam logic [7:0] PWR_RST = 8'h40;
  localparam logic [7:0] INT_MASK = 8'hf8;
  localparam logic [7:0] ATR_MASK = 8'h3f;
  localparam logic [7:0] DTR_MASK = 8'h07;
  localparam logic [7:0] PWR_MASK = 8'hc7;
  localparam logic [1:0] IDX_INT = 2'h0;
  localparam logic [1:0] IDX_ATR = 2'h1;
  localparam logic [1:0] IDX_DTR = 2'h2;
  localparam logic [1:0] IDX_PWR = 2'h3;
  localparam int INT_PULSED = 7;
  localparam int INT_EN_B = 6;
  localparam int INT_EN_A = 5;
  localparam int INT_SEL_HI = 4;
  localparam int INT_SEL_LO = 3;
  localparam int DTR_SIGN = 2;
  localparam int DTR_10PPM = 1;
  localparam int DTR_20PPM = 0;
  localparam int PWR_BUS_DIS = 7;
  localparam int PWR_SW_MODE = 6;
  localparam int SR_FLAG_B = 6;
  localparam int SR_FLAG_A = 5;
  localparam int SR_REGISTER_WRITE_ENABLE_LATCH = 2;
  localparam int SR_WEL = 1;
  localparam logic [7:0] SR_CMD_CLR = 8'h00;
  localparam logic [7:0] SR_CMD_WEL = 8'h02;
  localparam logic [7:0] SR_CMD_REGISTER_WRITE_ENABLE_LATCH = 8'h06;
  localparam logic [1:0] SEL_ALARM = 2'h0;
  localparam logic [1:0] SEL_32K = 2'h1;
  localparam logic [1:0] SEL_4K = 2'h2;
  localparam logic [1:0] SEL_1HZ = 2'h3;
  localparam int DIV_W = 15;
  localparam int DIV_4K_BIT = 2;
  localparam int DIV_1HZ_BIT = 14;
  // load capacitance in half picofarads
  localparam logic [6:0] CX_BASE_HPF = 7'h12;
  localparam logic [6:0] CX_B5_HPF = 7'h20;
  localparam logic [5:0] PPM_10 = 6'h0a;
  localparam logic [5:0] PPM_20 = 6'h14;
  // pulsed interrupt width and spacing, in oscillator periods
  localparam logic [2:0] IRQ_PULSE_OSC = 3'h4;
  localparam logic [2:0] IRQ_GAP_OSC = 3'h1;
  localparam logic [2:0] LEVEL_MAX = 3'h4;
  localparam logic [2:0] LEVEL_DEFAULT = 3'h0;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_END = 4'h9;
  typedef enum logic [2:0] {B_IDLE, B_DEV, B_AHI, B_ALO, B_WR, B_RD} rtp_bus_t;
endpackage

// file: rtl/rtp_nv_if.sv
// carrier between the control logic and the non-volatile control byte store
// assumes both sides run on the same core clock
`timescale 1ns/1ps
`default_nettype none
interface rtp_nv_if;
  logic rst_n;
  logic we;
  logic [1:0] idx;
  logic [7:0] wdata;
  logic [3:0][7:0] bytes;
  modport ctrl (output rst_n, output we, output idx, output wdata, input bytes);
  modport store (input rst_n, input we, input idx, input wdata, output bytes);
endinterface
`default_nettype wire

// file: rtl/rtp_nv_store.sv
// non-volatile control bytes: interrupt control, analog trim, digital trim, power control
// assumes its reset only comes with a factory restore, never with core reset
`timescale 1ns/1ps
`default_nettype none
module rtp_nv_store
  import rtp_pkg::*;
(
  input wire logic mclk, // core clock
  rtp_nv_if.store nv // write port and byte outputs
);
  typedef struct packed {
    logic [3:0][7:0] b;
  } rtp_nv_state_t;

  localparam logic [3:0][7:0] NV_MASK = {PWR_MASK, DTR_MASK, ATR_MASK, INT_MASK};
  localparam rtp_nv_state_t NV_DEF = '{b: {PWR_RST, DTR_RST, ATR_RST, INT_RST}};

  rtp_nv_state_t st_reg;
  rtp_nv_state_t st_next;

  always_comb begin
    st_next = st_reg;
    if (nv.we) begin
      st_next.b[nv.idx] = nv.wdata & NV_MASK[nv.idx];
    end
  end

  // only a factory restore reloads the factory contents, so the bytes outlive core resets
  always_ff @(posedge mclk or negedge nv.rst_n) begin
    if (!nv.rst_n) begin
      st_reg <= NV_DEF;
    end else begin
      st_reg <= st_next;
    end
  end

  assign nv.bytes = st_reg.b;

  write_kept_a:
  assert property (@(posedge mclk) disable iff (!nv.rst_n)
    nv.we |=> nv.bytes[$past(nv.idx)] == ($past(nv.wdata) & NV_MASK[$past(nv.idx)]))
    else $error("control byte write not stored");
endmodule // rtp_nv_store
`default_nettype wire

// file: rtl/rtp_ctrl.sv
// rtc alarm interrupt gating, clock-out divider, oscillator trim and power control, with i2c slave
// assumes scl, sda, osc and analog comparator levels are asynchronous pins; alarm matches are core-clock pulses
`timescale 1ns/1ps
`default_nettype none
module rtp_ctrl
  import rtp_pkg::*;
(
  input wire logic mclk, // core clock, 200 MHz
  input wire logic rstn, // core reset, active low
  input wire logic nv_rstn, // factory restore of control bytes, active low
  input wire logic scl_in, // serial clock pin
  input wire logic sda_in, // serial data pin level
  output logic sda_out, // serial data drive value, always low
  output logic sda_oe, // serial data pulled low when high
  input wire logic osc_in, // 32.768 kHz oscillator
  input wire logic alarm_a_match, // alarm a comparator match pulse
  input wire logic alarm_b_match, // alarm b comparator match pulse
  input wire logic vdd_below_reset, // supply below selected reset level
  input wire logic battery_mode, // running from the battery
  output logic irq_clkout_out, // shared pin drive value, always low
  output logic irq_clkout_oe, // shared pin pulled low when high
  output logic [6:0] load_cap_hpf, // crystal pin load capacitance, half pF
  output logic signed [5:0] trim_ppm, // digital trim correction in ppm
  output logic [2:0] reset_level_code, // supply reset level select
  output logic switchover_legacy, // legacy switchover mode
  output logic serial_bus_enabled, // serial interface usable
  output logic reset_out_n // reset output, active low
);
  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic [1:0] osc_s;
    logic [1:0] below_s;
    logic [1:0] bat_s;
    logic scl_d;
    logic sda_d;
    logic osc_d;
    rtp_bus_t bst;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] rb;
    logic [15:0] addr;
    logic ack_ok;
    logic write_enable_latch;
    logic register_write_enable_latch;
    logic ccr_wr;
    logic we;
    logic [1:0] idx;
    logic [7:0] wdata;
    logic flag_a;
    logic flag_b;
    logic pend_a;
    logic pend_b;
    logic plow;
    logic [2:0] pcnt;
    logic [DIV_W-1:0] div;
    logic sda_o;
    logic sda_oe;
    logic irq_oe;
    logic [6:0] cap;
    logic [5:0] ppm;
    logic [2:0] lvl;
    logic legacy;
    logic bus_en;
    logic rst_o_n;
  } rtp_state_t;

  rtp_nv_if nv ();
  logic [1:0] rs_reg;
  logic [1:0] nvr_reg;
  logic rst_n;
  rtp_state_t st_reg;
  rtp_state_t st_next;
  logic scl;
  logic sda;
  logic osc;
  logic bat;
  logic [7:0] ic;
  logic [7:0] at;
  logic [7:0] dt;
  logic [7:0] pw;
  logic [1:0] sel;
  logic en_a;
  logic en_b;
  logic pulsed;
  logic bus_off;

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rs_reg <= 2'h0;
    end else begin
      rs_reg <= {rs_reg[0], 1'b1};
    end
  end

  always_ff @(posedge mclk or negedge nv_rstn) begin
    if (!nv_rstn) begin
      nvr_reg <= 2'h0;
    end else begin
      nvr_reg <= {nvr_reg[0], 1'b1};
    end
  end

  assign rst_n = rs_reg[1];
  assign nv.rst_n = nvr_reg[1];
  assign nv.we = st_reg.we;
  assign nv.idx = st_reg.idx;
  assign nv.wdata = st_reg.wdata;

  rtp_nv_store u_store (
    .mclk(mclk),
    .nv(nv.store)
  );

  assign scl = st_reg.scl_s[1];
  assign sda = st_reg.sda_s[1];
  assign osc = st_reg.osc_s[1];
  assign bat = st_reg.bat_s[1];
  assign ic = nv.bytes[IDX_INT];
  assign at = nv.bytes[IDX_ATR];
  assign dt = nv.bytes[IDX_DTR];
  assign pw = nv.bytes[IDX_PWR];
  assign sel = {ic[INT_SEL_HI], ic[INT_SEL_LO]};
  assign en_a = ic[INT_EN_A];
  assign en_b = ic[INT_EN_B];
  assign pulsed = ic[INT_PULSED];
  // a supply below the reset level pulls reset_out_n low, which also mutes the bus
  assign bus_off = (bat & pw[PWR_BUS_DIS]) | ~st_reg.rst_o_n;

  function automatic logic [7:0] rd_byte(input logic [15:0] a);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      ADDR_INT: r = ic;
      ADDR_ATR: r = at;
      ADDR_DTR: r = dt;
      ADDR_PWR: r = pw;
      ADDR_SR: begin
        r[SR_FLAG_B] = st_reg.flag_b;
        r[SR_FLAG_A] = st_reg.flag_a;
        r[SR_REGISTER_WRITE_ENABLE_LATCH] = st_reg.register_write_enable_latch;
        r[SR_WEL] = st_reg.write_enable_latch;
      end
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  always_comb begin
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic otick;
    logic clr;
    logic [5:0] mag;
    logic [15:0] off;
    rtp_state_t s;
    s = st_reg;
    st_next = st_reg;
    rise = scl & ~s.scl_d;
    fall = ~scl & s.scl_d;
    start = scl & s.scl_d & ~sda & s.sda_d;
    stop = scl & s.scl_d & sda & ~s.sda_d;
    otick = osc & ~s.osc_d;
    clr = 1'b0;
    mag = (dt[DTR_10PPM] ? PPM_10 : 6'h00) + (dt[DTR_20PPM] ? PPM_20 : 6'h00);
    off = s.addr - ADDR_INT;
    st_next.scl_s = {s.scl_s[0], scl_in};
    st_next.sda_s = {s.sda_s[0], sda_in};
    st_next.osc_s = {s.osc_s[0], osc_in};
    st_next.below_s = {s.below_s[0], vdd_below_reset};
    st_next.bat_s = {s.bat_s[0], battery_mode};
    st_next.scl_d = scl;
    st_next.sda_d = sda;
    st_next.osc_d = osc;
    st_next.we = 1'b0;

    // power control
    st_next.rst_o_n = ~(s.below_s[1] | (bat & ~s.rst_o_n));
    st_next.lvl = (pw[2:0] > LEVEL_MAX) ? LEVEL_DEFAULT : pw[2:0];
    st_next.legacy = pw[PWR_SW_MODE];
    st_next.bus_en = ~bus_off;

    // trim: the oscillator core consumes ppm to stretch or shrink its count per second
    st_next.cap = (at[5] ? 7'h00 : CX_B5_HPF) + {2'h0, at[4:0]} + CX_BASE_HPF;
    st_next.ppm = dt[DTR_SIGN] ? (6'h00 - mag) : mag;

    if (otick) begin
      st_next.div = s.div + 1'b1;
    end

    // serial slave
    if (bus_off || stop) begin
      st_next.bst = B_IDLE;
      st_next.sda_oe = 1'b0;
      if (stop && s.ccr_wr) begin
        st_next.register_write_enable_latch = 1'b0;
        st_next.ccr_wr = 1'b0;
      end
    end else if (start) begin
      st_next.bst = B_DEV;
      st_next.cnt = 4'h0;
      st_next.sda_oe = 1'b0;
    end else if (s.bst != B_IDLE) begin
      if (rise) begin
        if (s.cnt == BIT_ACK) begin
          st_next.ack_ok = ~sda;
        end else begin
          st_next.sh = {s.sh[6:0], sda};
        end
        st_next.cnt = s.cnt + 4'h1;
      end else if (fall) begin
        if (s.cnt == BIT_ACK) begin
          st_next.sda_oe = (s.bst == B_DEV) ? (s.sh[7:1] == DEV_ADDR) : (s.bst != B_RD);
          if (s.bst == B_RD && s.addr == ADDR_SR) begin
            clr = 1'b1;
          end
        end else if (s.cnt == BIT_END) begin
          st_next.cnt = 4'h0;
          st_next.sda_oe = 1'b0;
          case (s.bst)
            B_DEV: begin
              if (s.sh[7:1] != DEV_ADDR) begin
                st_next.bst = B_IDLE;
              end else if (s.sh[0]) begin
                st_next.bst = B_RD;
                st_next.rb = rd_byte(s.addr);
              end else begin
                st_next.bst = B_AHI;
              end
            end
            B_AHI: begin
              st_next.addr[15:8] = s.sh;
              st_next.bst = B_ALO;
            end
            B_ALO: begin
              st_next.addr[7:0] = s.sh;
              st_next.bst = B_WR;
            end
            B_WR: begin
              st_next.addr = s.addr + ADDR_STEP;
              if (s.addr == ADDR_SR) begin
                if (s.sh == SR_CMD_CLR) begin
                  st_next.write_enable_latch = 1'b0;
                  st_next.register_write_enable_latch = 1'b0;
                end else if (s.sh == SR_CMD_WEL) begin
                  st_next.write_enable_latch = 1'b1;
                end else if (s.sh == SR_CMD_REGISTER_WRITE_ENABLE_LATCH && s.write_enable_latch) begin
                  st_next.register_write_enable_latch = 1'b1;
                end
              end else if (s.addr >= ADDR_INT && s.addr <= ADDR_PWR && s.register_write_enable_latch) begin
                // writes without both latches set are dropped silently
                st_next.we = 1'b1;
                st_next.idx = off[1:0];
                st_next.wdata = s.sh;
                st_next.ccr_wr = 1'b1;
              end
            end
            B_RD: begin
              if (!s.ack_ok) begin
                st_next.bst = B_IDLE;
              end else begin
                st_next.addr = s.addr + ADDR_STEP;
                st_next.rb = rd_byte(s.addr + ADDR_STEP);
              end
            end
            default: st_next.bst = B_IDLE;
          endcase
          if (st_next.bst == B_RD) begin
            st_next.sda_oe = ~st_next.rb[7];
          end
        end else if (s.bst == B_RD) begin
          st_next.sda_oe = ~s.rb[3'h7 - s.cnt[2:0]];
        end
      end
    end

    // pulse engine: low phase then a gap, so two alarms give two separate pulses
    if (!pulsed) begin
      st_next.pend_a = 1'b0;
      st_next.pend_b = 1'b0;
    end
    if (!en_a) begin
      st_next.pend_a = 1'b0;
    end
    if (!en_b) begin
      st_next.pend_b = 1'b0;
    end
    if (s.pcnt != 3'h0) begin
      if (otick) begin
        st_next.pcnt = s.pcnt - 3'h1;
        if (s.pcnt == 3'h1 && s.plow) begin
          st_next.plow = 1'b0;
          st_next.pcnt = IRQ_GAP_OSC;
        end
      end
    end else if (s.pend_a || s.pend_b) begin
      st_next.plow = 1'b1;
      st_next.pcnt = IRQ_PULSE_OSC;
      if (s.pend_a) begin
        st_next.pend_a = 1'b0;
      end else begin
        st_next.pend_b = 1'b0;
      end
    end
    if (alarm_a_match && en_a && pulsed) begin
      st_next.pend_a = 1'b1;
    end
    if (alarm_b_match && en_b && pulsed) begin
      st_next.pend_b = 1'b1;
    end

    // a match in the clearing cycle wins over the clear
    st_next.flag_a = alarm_a_match | (s.flag_a & ~clr);
    st_next.flag_b = alarm_b_match | (s.flag_b & ~clr);

    case (sel)
      SEL_ALARM: st_next.irq_oe = (en_a | en_b) & (pulsed ? s.plow
                   : ((s.flag_a & en_a) | (s.flag_b & en_b)));
      SEL_32K: st_next.irq_oe = ~osc;
      SEL_4K: st_next.irq_oe = ~s.div[DIV_4K_BIT];
      SEL_1HZ: st_next.irq_oe = ~s.div[DIV_1HZ_BIT];
      default: st_next.irq_oe = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sda_out = st_reg.sda_o;
  assign sda_oe = st_reg.sda_oe;
  assign irq_clkout_out = st_reg.sda_o;
  assign irq_clkout_oe = st_reg.irq_oe;
  assign load_cap_hpf = st_reg.cap;
  assign trim_ppm = st_reg.ppm;
  assign reset_level_code = st_reg.lvl;
  assign switchover_legacy = st_reg.legacy;
  assign serial_bus_enabled = st_reg.bus_en;
  assign reset_out_n = st_reg.rst_o_n;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_single_hit;
    alarm_a_match && en_a && !pulsed && sel == SEL_ALARM && !nv.we;
  endsequence
  sequence s_flag_then_pin;
    st_reg.flag_a ##1 irq_clkout_oe;
  endsequence
  sequence s_pulse_go;
    st_reg.pcnt == 3'h0 && (st_reg.pend_a || st_reg.pend_b) && sel == SEL_ALARM && !nv.we;
  endsequence

  alarm_gate_a:
  assert property (!(en_a || en_b) && sel == SEL_ALARM |=> !irq_clkout_oe)
    else $error("alarm pin driven with no enable");
  clkout_sel_a:
  assert property (sel == SEL_4K && !nv.we |=> irq_clkout_oe == !$past(st_reg.div[DIV_4K_BIT]))
    else $error("4096 Hz output not from divider");
  single_hold_a:
  assert property (s_single_hit |=> s_flag_then_pin)
    else $error("single event did not pull the pin");
  pulse_start_a:
  assert property (s_pulse_go |=> st_reg.plow ##1 irq_clkout_oe)
    else $error("pending alarm did not pulse the pin");
  pulse_width_a:
  assert property ($rose(st_reg.plow) |-> st_reg.pcnt == IRQ_PULSE_OSC)
    else $error("pulse width not loaded");
  flag_clear_a:
  assert property (st_reg.bst == B_RD && st_reg.addr == ADDR_SR && st_reg.cnt == BIT_ACK
    && !scl && st_reg.scl_d && !bus_off && !alarm_a_match |=> !st_reg.flag_a)
    else $error("status read did not clear flag");
  bat_reset_a:
  assert property (!reset_out_n && bat |=> !reset_out_n)
    else $error("battery reset released early");
  bus_mute_a:
  assert property (bat && pw[PWR_BUS_DIS] |=> !sda_oe && st_reg.bst == B_IDLE)
    else $error("bus active while disabled on battery");
  level_map_a:
  assert property (pw[2:0] > LEVEL_MAX && !nv.we |=> reset_level_code == LEVEL_DEFAULT)
    else $error("undefined level code not mapped");
  trim_zero_a:
  assert property (dt[2:0] == 3'h4 && !nv.we |=> trim_ppm == 6'sh00)
    else $error("negative zero trim applied a correction");
endmodule // rtp_ctrl
`default_nettype wire

// file: test/rtp_host.sv
// i2c host model: byte and transfer tasks on scl and an open-drain data line
// assumes a pull-up resolves sda outside; everything runs on the core clock
`timescale 1ns/1ps
`default_nettype none
module rtp_host
  import rtp_pkg::*;
#(parameter int H = 8)
(
  input wire logic mclk, // core clock
  input wire logic sda, // resolved data line
  output logic scl, // serial clock
  output logic sda_low // pulls data low when high
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic wt();
    repeat (H) @(posedge mclk);
  endtask
  // data moves two edges after scl falls so the device never sees both change together
  task automatic bit_io(input logic b, output logic r);
    repeat (2) @(posedge mclk);
    sda_low <= ~b;
    wt();
    scl <= 1'b1;
    wt();
    r = sda;
    scl <= 1'b0;
  endtask
  task automatic start();
    repeat (2) @(posedge mclk);
    sda_low <= 1'b0;
    wt();
    scl <= 1'b1;
    wt();
    sda_low <= 1'b1;
    wt();
    scl <= 1'b0;
  endtask
  task automatic stop();
    repeat (2) @(posedge mclk);
    sda_low <= 1'b1;
    wt();
    scl <= 1'b1;
    wt();
    sda_low <= 1'b0;
    wt();
  endtask
  task automatic xbyte(input logic [7:0] d, input logic last, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(last, r);
    ack = ~r;
  endtask
  // first byte sits in byte n-1 of wd and rdat, the top of the n bytes used
  task automatic xfer(input logic [15:0] a, input int n, input logic rd, input logic [31:0] wd,
                      output logic [31:0] rdat, output logic ok);
    logic [7:0] q;
    logic k;
    ok = 1'b1;
    rdat = '0;
    start();
    xbyte({DEV_ADDR, 1'b0}, 1'b1, q, k);
    ok = ok & k;
    xbyte(a[15:8], 1'b1, q, k);
    ok = ok & k;
    xbyte(a[7:0], 1'b1, q, k);
    ok = ok & k;
    if (rd) begin
      start();
      xbyte({DEV_ADDR, 1'b1}, 1'b1, q, k);
      ok = ok & k;
    end
    for (int i = n - 1; i >= 0; i--) begin
      xbyte(rd ? 8'hff : wd[8*i+:8], rd ? (i == 0) : 1'b1, q, k);
      rdat[8*i+:8] = q;
      if (!rd) ok = ok & k;
    end
    stop();
  endtask
endmodule // rtp_host
`default_nettype wire

// file: test/testbench.sv
// self-checking bench: host model on the serial bus, oscillator, alarm pulses and supply levels
// assumes rtp_ctrl holds its own control byte store behind the serial bus
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rtp_pkg::*;
  // oscillator far faster than a crystal so the 4096 Hz divider tap and pulse spans fit the run
  localparam int OSC_H = 40;
  logic mclk, rstn, nv_rstn, osc_in, a_m, b_m, vbelow, batt, scl, host_low, sda_oe, irq_oe;
  logic sbe, legacy, rst_out_n, ok, po, sda_o, irq_o;
  logic [6:0] cap;
  logic signed [5:0] ppm;
  logic [2:0] lvl, c;
  logic [7:0] pw;
  logic [5:0] pe;
  logic [31:0] q;
  logic [7:0] atr_tab [8] = '{8'h00, 8'h20, 8'h1f, 8'h3f, 8'h01, 8'h10, 8'h2a, 8'h15};
  int exp_tab [5] = '{1, 32, 4, 0, 0};
  int num_errors = 0;
  int cmp_count = 0;
  int cnt, w;
  wire logic sda_w = !(host_low || sda_oe);
  rtp_ctrl rtp_ctrl_i(.mclk(mclk), .rstn(rstn), .nv_rstn(nv_rstn), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_o), .sda_oe(sda_oe), .osc_in(osc_in), .alarm_a_match(a_m), .alarm_b_match(b_m),
    .vdd_below_reset(vbelow), .battery_mode(batt), .irq_clkout_out(irq_o), .irq_clkout_oe(irq_oe),
    .load_cap_hpf(cap), .trim_ppm(ppm), .reset_level_code(lvl), .switchover_legacy(legacy),
    .serial_bus_enabled(sbe), .reset_out_n(rst_out_n));
  rtp_host rtp_host_i(.mclk(mclk), .sda(sda_w), .scl(scl), .sda_low(host_low));
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic end_sim();
    if (num_errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input int n, input logic [31:0] d);
    logic [31:0] r;
    logic k;
    rtp_host_i.xfer(ADDR_SR, 1, 1'b0, {24'h0, SR_CMD_WEL}, r, k);
    rtp_host_i.xfer(ADDR_SR, 1, 1'b0, {24'h0, SR_CMD_REGISTER_WRITE_ENABLE_LATCH}, r, k);
    rtp_host_i.xfer(a, n, 1'b0, d, r, k);
    repeat (8) @(posedge mclk);
  endtask
  task automatic rd(input logic [15:0] a, input int n);
    rtp_host_i.xfer(a, n, 1'b1, 32'h0, q, ok);
    repeat (8) @(posedge mclk);
  endtask
  task automatic fire(input logic a, input logic b);
    a_m <= a;
    b_m <= b;
    @(posedge mclk);
    a_m <= 1'b0;
    b_m <= 1'b0;
  endtask
  task automatic watch(input int n);
    cnt = 0;
    w = 0;
    po = irq_oe;
    repeat (n) begin
      @(posedge mclk);
      cnt += int'(irq_oe & ~po);
      w += int'(irq_oe);
      po = irq_oe;
    end
  endtask
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    osc_in = 1'b0;
    forever begin
      repeat (OSC_H) @(posedge mclk);
      osc_in <= ~osc_in;
    end
  end
  initial begin
    repeat (100000) @(posedge mclk);
    num_errors++;
    end_sim();
  end
  initial begin
    {rstn, nv_rstn, a_m, b_m, vbelow, batt} = 6'h00;
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    nv_rstn <= 1'b1;
    repeat (20) @(posedge mclk);
    rd(ADDR_INT, 4);
    check("defaults", q, {INT_RST, ATR_RST, DTR_RST, PWR_RST});
    check("cap default", cap, CX_BASE_HPF + CX_B5_HPF);
    check("bus and mode", {sbe, legacy, rst_out_n}, 3'b111);
    check("open drain values", {sda_o, irq_o}, 2'b00);
    rtp_host_i.xfer(ADDR_ATR, 1, 1'b0, 32'h3f, q, ok);
    rd(ADDR_ATR, 1);
    check("locked atr", q, 32'h0);
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      pw = {1'b0, c[0], 3'b000, c};
      wr(ADDR_ATR, 3, {8'h0, atr_tab[i], 5'h00, c, pw});
      rd(ADDR_ATR, 3);
      check("trim bytes", q, {8'h0, atr_tab[i], 5'h00, c, pw});
      check("load cap", cap, CX_BASE_HPF + (atr_tab[i][5] ? 7'h00 : CX_B5_HPF) + {2'b00, atr_tab[i][4:0]});
      pe = (c[1] ? PPM_10 : 6'h00) + (c[0] ? PPM_20 : 6'h00);
      pe = c[2] ? 6'h00 - pe : pe;
      check("trim ppm", $unsigned(ppm), pe);
      check("reset level", lvl, c > LEVEL_MAX ? LEVEL_DEFAULT : c);
      check("switchover", legacy, c[0]);
    end
    rstn <= 1'b0;
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    repeat (20) @(posedge mclk);
    rd(ADDR_ATR, 1);
    check("kept atr", q, {24'h0, atr_tab[7]});
    wr(ADDR_PWR, 1, 32'h40);
    vbelow <= 1'b1;
    repeat (10) @(posedge mclk);
    check("reset low", rst_out_n, 1'b0);
    rd(ADDR_INT, 1);
    check("bus silent", ok, 1'b0);
    batt <= 1'b1;
    vbelow <= 1'b0;
    repeat (10) @(posedge mclk);
    check("reset held", rst_out_n, 1'b0);
    batt <= 1'b0;
    repeat (10) @(posedge mclk);
    check("reset freed", rst_out_n, 1'b1);
    for (int m = 0; m < 2; m++) begin
      wr(ADDR_PWR, 1, m ? 32'hc0 : 32'h40);
      batt <= 1'b1;
      repeat (10) @(posedge mclk);
      check("bus in battery", sbe, m == 0);
      rd(ADDR_INT, 1);
      check("battery ack", ok, m == 0);
      batt <= 1'b0;
      repeat (10) @(posedge mclk);
    end
    for (int s = 4; s >= 0; s--) begin
      rd(ADDR_SR, 1);
      wr(ADDR_INT, 1, s == 4 ? 32'h0 : {24'h0, 3'b001, 2'(s), 3'b000});
      fire(1'b1, 1'b0);
      watch(64 * OSC_H);
      check("pin edges", cnt >= exp_tab[s] - int'(s inside {[1:3]}) && cnt <= exp_tab[s] + int'(s inside {[1:3]}), 1);
    end
    check("irq held", irq_oe, 1'b1);
    rd(ADDR_SR, 1);
    check("flag set", q & 32'h60, 32'h20);
    check("irq freed", irq_oe, 1'b0);
    rd(ADDR_SR, 1);
    check("flag clear", q & 32'h60, 32'h0);
    wr(ADDR_INT, 1, 32'he0);
    fire(1'b1, 1'b1);
    watch(32 * OSC_H);
    check("two pulses", cnt, 2);
    check("pulse width", w >= 14 * OSC_H && w <= 18 * OSC_H, 1);
    fire(1'b1, 1'b0);
    watch(16 * OSC_H);
    check("repeat pulse", cnt, 1);
    rd(ADDR_SR, 1);
    check("both flags", q & 32'h60, 32'h60);
    end_sim();
  end
endmodule // testbench
`default_nettype wire
